// *** hw/reference_monitor_config.sv ***
// configuration bank and input path for two monitored clock references
// assumes monitor levels are synchronous; reference pins are not
// assumes register strobes are single-cycle pulses on ref_clk
//
// Behaviour
// - bits 3:0 of failure enable gate reference 0 indicators los,scm,cfm,gst
// - enable bit zero blocks its indicator, one lets it through
// - blocked indicators never set the failure interrupt status at 0x02
// - raw failure register at 0x07 records every indicator, never gated
// - bits 7:4 give the same four enables for reference 1
// - halve enable high divides that reference clock by two
// - halve enable low passes that reference clock straight through
// - select bits 4 and 5 choose differential or positive-pin input
// - two-bit disqualify code picks minimum, 10 ms, 50 ms or 2.5 s
// - scm or cfm starts disqualify delay; reference dropped when elapsed
// - qualify code picks 2, 4, 6 or 8 disqualify periods
// - qualify delay starts after scm and cfm both clear, then accepted
// - freeze 0x01 stops status updates, 0x00 resumes them
// - guard timer expiry sets the guard soak failure indicator
`timescale 1ns/10ps
module reference_monitor_config #(
	parameter int unsigned T1_CYC = refmon_pkg::DROP_T1_CYC,
	parameter int unsigned T2_CYC = refmon_pkg::DROP_T2_CYC,
	parameter int unsigned T3_CYC = refmon_pkg::DROP_T3_CYC
) (
	input wire logic ref_clk, // 40 MHz system clock
	input wire logic rstn, // async reset, active low
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe, one cycle
	input wire logic reg_rd, // read strobe, one cycle
	output logic [7:0] reg_rdata, // read data, one cycle after strobe
	input wire logic [7:0] fail_level, // monitor levels, raw layout
	input wire logic input0_positive_pin, // reference 0 positive pin
	input wire logic input0_negative_pin, // reference 0 negative pin
	input wire logic input1_positive_pin, // reference 1 positive pin
	input wire logic input1_negative_pin, // reference 1 negative pin
	output logic [1:0] tracked_clk, // clocks toward the tracking loop
	output logic [1:0] input_qualified, // guard timer verdict
	output logic [1:0] ref_fail_flags // interrupt status bits
);
	// per reference slice widths inside the packed byte registers
	localparam int N = refmon_pkg::NREF;
	localparam int W = refmon_pkg::IND_W;
	localparam int F = refmon_pkg::FIELD_W;

	// software visible registers and their next values
	logic [7:0] fail_enable, next_fail_enable;
	logic [7:0] input_setup, next_input_setup;
	logic [7:0] drop_delay, next_drop_delay;
	logic [7:0] accept_delay, next_accept_delay;
	logic [7:0] freeze, next_freeze;
	logic [7:0] latched_status, next_latched_status;
	logic [7:0] pend_raw, next_pend_raw;
	logic [1:0] isr, next_isr;
	logic [1:0] pend_isr, next_pend_isr;
	logic [7:0] next_rdata;
	logic [7:0] events;
	logic [1:0] isr_set;
	logic frozen;
	// reference clock path, one bit per input
	logic [N-1:0] pos_pin, neg_pin;
	logic [N-1:0] pos_s1, pos_s2, neg_s1, neg_s2;
	logic [N-1:0] sel, sel_prev, div, next_div, next_clk, next_sel_prev;
	logic [N-1:0] qual_w;

	assign pos_pin = {input1_positive_pin, input0_positive_pin};
	assign neg_pin = {input1_negative_pin, input0_negative_pin};
	assign frozen = (freeze == refmon_pkg::FREEZE_ON);

	// one timer link per reference: config out, verdict and expiry back
	guard_if gif[N] ();

	// per reference: input receiver, halving, guard timer, gating
	for (genvar r = 0; r < N; r++) begin : g_ref
		// differential receiver modelled as positive high, negative low
		assign sel[r] = input_setup[refmon_pkg::BAL_BASE + r] ?
			(pos_s2[r] & ~neg_s2[r]) : pos_s2[r];
		// divider toggles on each rising edge of the selected input
		assign next_sel_prev[r] = sel[r];
		assign next_div[r] = (sel[r] & ~sel_prev[r]) ? ~div[r] : div[r];
		assign next_clk[r] = input_setup[refmon_pkg::HALVE_BASE + r] ?
			div[r] : sel[r];
		// scm or cfm of this reference starts the disqualify delay
		assign gif[r].fail = fail_level[r*W + refmon_pkg::IND_SCM] |
			fail_level[r*W + refmon_pkg::IND_CFM];
		assign gif[r].drop_code = drop_delay[r*F +: F];
		assign gif[r].accept_code = accept_delay[r*F +: F];
		assign qual_w[r] = gif[r].qualified;
		// los, scm and cfm come from monitors, gst from the timer
		assign events[r*W +: 3] = fail_level[r*W +: 3];
		assign events[r*W + refmon_pkg::IND_GST] = gif[r].expire;
		// only enabled indicators reach the interrupt status
		assign isr_set[r] = |(events[r*W +: W] &
			fail_enable[r*W +: W]);

		// los has no soak behaviour, so the timer never sees it
		guard_timer #(
			.T1_CYC(T1_CYC),
			.T2_CYC(T2_CYC),
			.T3_CYC(T3_CYC)
		) guard_timer_i (
			.ref_clk(ref_clk),
			.rstn(rstn),
			.g(gif[r])
		);
	end

	// pin synchronisers and the clock path registers
	// pins are sampled, so references near half of ref_clk or above alias
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pos_s1 <= '0;
			pos_s2 <= '0;
			neg_s1 <= '0;
			neg_s2 <= '0;
			sel_prev <= '0;
			div <= '0;
			tracked_clk <= '0;
			input_qualified <= '1;
		end else begin
			pos_s1 <= pos_pin;
			pos_s2 <= pos_s1;
			neg_s1 <= neg_pin;
			neg_s2 <= neg_s1;
			sel_prev <= next_sel_prev;
			div <= next_div;
			tracked_clk <= next_clk;
			input_qualified <= qual_w;
		end
	end

	// register writes and status; hardware set wins over software clear
	always_comb begin
		next_fail_enable = fail_enable;
		next_input_setup = input_setup;
		next_drop_delay = drop_delay;
		next_accept_delay = accept_delay;
		next_freeze = freeze;
		next_latched_status = latched_status;
		next_isr = isr;
		next_pend_raw = pend_raw;
		next_pend_isr = pend_isr;
		// software writes first; status bits clear where a one is written
		if (reg_wr) begin
			case (reg_addr)
				refmon_pkg::ADDR_ENABLE: next_fail_enable = reg_wdata;
				refmon_pkg::ADDR_SETUP: next_input_setup = reg_wdata;
				refmon_pkg::ADDR_DROP: next_drop_delay = reg_wdata;
				refmon_pkg::ADDR_ACCEPT: next_accept_delay = reg_wdata;
				refmon_pkg::ADDR_FREEZE: next_freeze = reg_wdata;
				refmon_pkg::ADDR_RAW:
					next_latched_status = latched_status & ~reg_wdata;
				refmon_pkg::ADDR_ISR: next_isr = isr & ~reg_wdata[1:0];
				default: ;
			endcase
		end
		// hardware sets come after the clear, so a set in one cycle wins
		if (frozen) begin
			// held events are merged once the freeze lifts
			next_pend_raw = pend_raw | events;
			next_pend_isr = pend_isr | isr_set;
		end else begin
			next_latched_status = next_latched_status | events |
				pend_raw;
			next_isr = next_isr | isr_set | pend_isr;
			next_pend_raw = '0;
			next_pend_isr = '0;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		next_rdata = reg_rdata;
		// reads never clear status; the port sees the registered copy
		if (reg_rd) begin
			case (reg_addr)
				refmon_pkg::ADDR_ENABLE: next_rdata = fail_enable;
				refmon_pkg::ADDR_SETUP: next_rdata = input_setup;
				refmon_pkg::ADDR_DROP: next_rdata = drop_delay;
				refmon_pkg::ADDR_ACCEPT: next_rdata = accept_delay;
				refmon_pkg::ADDR_FREEZE: next_rdata = freeze;
				refmon_pkg::ADDR_RAW: next_rdata = latched_status;
				refmon_pkg::ADDR_ISR: next_rdata = {6'h00, isr};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// register bank
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			// configuration comes up at its default values
			fail_enable <= refmon_pkg::RST_ENABLE;
			input_setup <= refmon_pkg::RST_SETUP;
			drop_delay <= refmon_pkg::RST_DROP;
			accept_delay <= refmon_pkg::RST_ACCEPT;
			freeze <= refmon_pkg::RST_FREEZE;
			latched_status <= '0;
			pend_raw <= '0;
			isr <= '0;
			pend_isr <= '0;
			reg_rdata <= '0;
			ref_fail_flags <= '0;
		end else begin
			fail_enable <= next_fail_enable;
			input_setup <= next_input_setup;
			drop_delay <= next_drop_delay;
			accept_delay <= next_accept_delay;
			freeze <= next_freeze;
			latched_status <= next_latched_status;
			pend_raw <= next_pend_raw;
			isr <= next_isr;
			pend_isr <= next_pend_isr;
			reg_rdata <= next_rdata;
			// flag pins take the same next value, so they equal isr
			ref_fail_flags <= next_isr;
		end
	end
endmodule : reference_monitor_config

// *** hw/refmon_pkg.sv ***
// constants and types for the reference monitor configuration block
// assumes a byte-wide register port on the device system clock
package refmon_pkg;
	localparam int NREF = 2;
	localparam int IND_W = 4;
	localparam int IND_LOS = 0;
	localparam int IND_SCM = 1;
	localparam int IND_CFM = 2;
	localparam int IND_GST = 3;
	localparam int HALVE_BASE = 0;
	localparam int BAL_BASE = 4;
	localparam int FIELD_W = 2;

	// register offsets on the byte register port
	localparam logic [7:0] ADDR_ISR = 8'h02;
	localparam logic [7:0] ADDR_RAW = 8'h07;
	localparam logic [7:0] ADDR_ENABLE = 8'h09;
	localparam logic [7:0] ADDR_SETUP = 8'h0A;
	localparam logic [7:0] ADDR_DROP = 8'h0B;
	localparam logic [7:0] ADDR_ACCEPT = 8'h0C;
	localparam logic [7:0] ADDR_FREEZE = 8'h0D;

	// reset values and the freeze-on code
	localparam logic [7:0] RST_ENABLE = 8'h66;
	localparam logic [7:0] RST_SETUP = 8'h10;
	localparam logic [7:0] RST_DROP = 8'hAA;
	localparam logic [7:0] RST_ACCEPT = 8'h55;
	localparam logic [7:0] RST_FREEZE = 8'h00;
	localparam logic [7:0] FREEZE_ON = 8'h01;

	// delay codes and their times
	localparam logic [1:0] CODE_MIN = 2'h0;
	localparam logic [1:0] CODE_T1 = 2'h1;
	localparam logic [1:0] CODE_T2 = 2'h2;
	localparam int CLK_MHZ = 40;
	localparam int DROP_T1_US = 10000;
	localparam int DROP_T2_US = 50000;
	localparam int DROP_T3_US = 2500000;
	localparam int DROP_T1_CYC = DROP_T1_US * CLK_MHZ;
	localparam int DROP_T2_CYC = DROP_T2_US * CLK_MHZ;
	localparam int DROP_T3_CYC = DROP_T3_US * CLK_MHZ;
	localparam int CNT_W = 27;
	localparam int REP_W = 3;

	typedef enum logic [3:0] {
		ST_OK = 4'h1,
		ST_DROP = 4'h2,
		ST_BAD = 4'h4,
		ST_ACCEPT = 4'h8
	} guard_state_t;
endpackage : refmon_pkg

// *** hw/guard_if.sv ***
// link between the configuration bank and one guard soak timer
// assumes both ends run on the same system clock
`timescale 1ns/10ps
interface guard_if;
	logic fail;
	logic [1:0] drop_code;
	logic [1:0] accept_code;
	logic qualified;
	logic expire;
	modport ctrl (output fail, drop_code, accept_code,
		input qualified, expire);
	modport timer (input fail, drop_code, accept_code,
		output qualified, expire);
endinterface : guard_if

// *** hw/guard_timer.sv ***
// guard soak timer for one reference: disqualify and qualify delays
// assumes fail is a same-clock level from the frequency monitors
`timescale 1ns/10ps
module guard_timer #(
	parameter int unsigned T1_CYC = refmon_pkg::DROP_T1_CYC,
	parameter int unsigned T2_CYC = refmon_pkg::DROP_T2_CYC,
	parameter int unsigned T3_CYC = refmon_pkg::DROP_T3_CYC
) (
	input wire logic ref_clk, // system clock
	input wire logic rstn, // async reset, active low
	guard_if.timer g // config in, qualification out
);
	localparam int CW = refmon_pkg::CNT_W;
	localparam int RW = refmon_pkg::REP_W;
	refmon_pkg::guard_state_t state, next_state;
	logic [CW-1:0] cnt, next_cnt, limit_last;
	logic [RW-1:0] rep, next_rep, rep_last;
	logic next_qual, next_expire;

	// last count of one disqualify period; minimum code is one cycle
	always_comb begin
		case (g.drop_code)
			refmon_pkg::CODE_MIN: limit_last = '0;
			refmon_pkg::CODE_T1: limit_last = CW'(T1_CYC - 1);
			refmon_pkg::CODE_T2: limit_last = CW'(T2_CYC - 1);
			default: limit_last = CW'(T3_CYC - 1);
		endcase
	end

	// qualify lasts 2, 4, 6 or 8 disqualify periods
	assign rep_last = {g.accept_code, 1'b1};

	// next state; >= tolerates the delay code shrinking mid-count
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_rep = rep;
		next_qual = g.qualified;
		next_expire = 1'b0;
		case (state)
			refmon_pkg::ST_OK: begin
				if (g.fail) begin
					next_state = refmon_pkg::ST_DROP;
					next_cnt = '0;
				end
			end
			refmon_pkg::ST_DROP: begin
				if (cnt >= limit_last) begin
					next_state = refmon_pkg::ST_BAD;
					next_qual = 1'b0;
					next_expire = 1'b1;
				end else if (!g.fail) begin
					next_state = refmon_pkg::ST_OK;
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			refmon_pkg::ST_BAD: begin
				if (!g.fail) begin
					next_state = refmon_pkg::ST_ACCEPT;
					next_cnt = '0;
					next_rep = '0;
				end
			end
			refmon_pkg::ST_ACCEPT: begin
				if (g.fail) begin
					next_state = refmon_pkg::ST_BAD;
				end else if (cnt >= limit_last) begin
					next_cnt = '0;
					if (rep >= rep_last) begin
						next_state = refmon_pkg::ST_OK;
						next_qual = 1'b1;
					end else begin
						next_rep = rep + 1'b1;
					end
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			default: next_state = refmon_pkg::ST_OK;
		endcase
	end

	// state registers
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state <= refmon_pkg::ST_OK;
			cnt <= '0;
			rep <= '0;
			g.qualified <= 1'b1;
			g.expire <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			rep <= next_rep;
			g.qualified <= next_qual;
			g.expire <= next_expire;
		end
	end
endmodule : guard_timer

// *** sim/ref_source.sv ***
// behavioural clock source wired to one reference input pin pair
// assumes the bench chooses how the negative pin is wired
`timescale 1ns/10ps
module ref_source #(
	parameter real HALF_NS = 251.0
) (
	input wire logic [1:0] n_mode, // 0 inverse, 1 same as p, 2 ground
	output logic pin_p, // positive pin
	output logic pin_n // negative pin
);
	// free running: an oscillator never pauses between uses
	initial begin
		pin_p = 1'b0;
		forever #(HALF_NS) pin_p = ~pin_p;
	end
	// common-mode wiring shows whether the receiver really subtracts
	assign pin_n = n_mode == 2'h0 ? ~pin_p : n_mode == 2'h1 ? pin_p : 1'b0;
endmodule : ref_source

// *** sim/reference_monitor_config_checker.sv ***
// port assertions for the reference monitor configuration block
// assumes bound into every instance of the block
`timescale 1ns/10ps
module refmon_checker #(
	parameter int unsigned T1_CYC = 4,
	parameter int unsigned T2_CYC = 8,
	parameter int unsigned T3_CYC = 16
) (
	input wire logic ref_clk, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic [7:0] reg_addr, // address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [7:0] reg_rdata, // read data
	input wire logic [7:0] fail_level, // monitor levels
	input wire logic [1:0] input_qualified, // verdicts
	input wire logic [1:0] ref_fail_flags // interrupt status
);
	logic [7:0] en;
	logic frz;
	logic [1:0] dc;
	logic [1:0] ac;
	int unsigned fcnt;
	int unsigned ccnt;
	int unsigned lim;
	wire logic fail0 = fail_level[1] | fail_level[2];
	wire logic w1c0 = reg_wr && reg_addr == refmon_pkg::ADDR_ISR && reg_wdata[0];
	wire logic wen = reg_wr && reg_addr == refmon_pkg::ADDR_ENABLE;
	// shadows of written fields and runs of fail and no-fail cycles
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			en <= refmon_pkg::RST_ENABLE;
			frz <= 1'b0;
			dc <= 2'h2;
			ac <= 2'h1;
			fcnt <= 0;
			ccnt <= 0;
		end else begin
			if (wen) en <= reg_wdata;
			if (reg_wr && reg_addr == refmon_pkg::ADDR_FREEZE)
				frz <= reg_wdata == refmon_pkg::FREEZE_ON;
			if (reg_wr && reg_addr == refmon_pkg::ADDR_DROP) dc <= reg_wdata[1:0];
			if (reg_wr && reg_addr == refmon_pkg::ADDR_ACCEPT) ac <= reg_wdata[1:0];
			fcnt <= fail0 ? fcnt + 1 : 0;
			ccnt <= fail0 ? 0 : ccnt + 1;
		end
	end
	assign lim = dc == 2'h0 ? 1 : dc == 2'h1 ? T1_CYC :
		dc == 2'h2 ? T2_CYC : T3_CYC;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	AST_ISR_REF0:
	assert property (!frz && |(fail_level[2:0] & en[2:0]) |-> ##[1:2]
		ref_fail_flags[0]) else $error("isr0 not set");
	AST_ISR_REF1:
	assert property (!frz && |(fail_level[6:4] & en[6:4]) |-> ##[1:2]
		ref_fail_flags[1]) else $error("isr1 not set");
	AST_ISR_STICKY:
	assert property ($fell(ref_fail_flags[0]) |-> $past(w1c0) || $past(w1c0, 2))
		else $error("isr0 cleared without write");
	AST_FREEZE:
	assert property (frz && $past(frz) && $past(frz, 2) |->
		(ref_fail_flags & ~$past(ref_fail_flags)) == 2'b00)
		else $error("isr set while frozen");
	AST_DROP_TIME:
	assert property ($fell(input_qualified[0]) |-> fcnt >= lim && fcnt <= lim + 3)
		else $error("disqualify delay wrong");
	AST_ACCEPT_TIME:
	assert property ($rose(input_qualified[0]) |-> ccnt >= (2 * ac + 2) * lim
		&& ccnt <= (2 * ac + 2) * lim + 4) else $error("qualify delay wrong");
	AST_RD_ENABLE:
	assert property (reg_rd && reg_addr == refmon_pkg::ADDR_ENABLE |=>
		reg_rdata == $past(en)) else $error("enable readback wrong");
	AST_RD_HOLD:
	assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
	cover property ($rose(ref_fail_flags[0]));
	cover property ($fell(input_qualified[0]));
	cover property ($rose(input_qualified[0]));
	cover property (frz && fail0);
endmodule : refmon_checker
bind reference_monitor_config refmon_checker #(.T1_CYC(T1_CYC),
	.T2_CYC(T2_CYC), .T3_CYC(T3_CYC)) refmon_checker_i (.ref_clk, .rstn,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fail_level,
	.input_qualified, .ref_fail_flags);

// *** sim/reference_monitor_config_tb.sv ***
// self-checking bench for the reference monitor configuration block
// assumes the checker is bound and ref_source drives the pins
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	n_errors++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module reference_monitor_config_tb;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] fail_level = 8'h00;
	logic [1:0] m0 = 2'h0;
	logic [7:0] reg_rdata;
	logic [1:0] tracked_clk;
	logic [1:0] input_qualified;
	logic [1:0] ref_fail_flags;
	logic p0, n0, p1, n1;
	int n_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	ref_source src0_i (.n_mode(m0), .pin_p(p0), .pin_n(n0));
	ref_source src1_i (.n_mode(2'h2), .pin_p(p1), .pin_n(n1));
	reference_monitor_config #(.T1_CYC(4), .T2_CYC(8), .T3_CYC(16))
		reference_monitor_config_i (.ref_clk, .rstn, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .fail_level, .input0_positive_pin(p0),
		.input0_negative_pin(n0), .input1_positive_pin(p1),
		.input1_negative_pin(n1), .tracked_clk, .input_qualified,
		.ref_fail_flags);
	task automatic finish_test();
		if (n_errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		`CHK(nm, e, reg_rdata)
	endtask : rd
	task automatic pulse(input logic [7:0] l);
		@(negedge ref_clk);
		fail_level = l;
		@(negedge ref_clk);
		fail_level = 8'h00;
		repeat (3) @(negedge ref_clk);
	endtask : pulse
	task automatic clr();
		wr(refmon_pkg::ADDR_RAW, 8'hFF);
		wr(refmon_pkg::ADDR_ISR, 8'hFF);
	endtask : clr
	task automatic t_reset();
		rd(refmon_pkg::ADDR_ENABLE, 8'h66, "enable");
		rd(refmon_pkg::ADDR_SETUP, 8'h10, "setup");
		rd(refmon_pkg::ADDR_DROP, 8'hAA, "drop");
		rd(refmon_pkg::ADDR_ACCEPT, 8'h55, "accept");
		rd(refmon_pkg::ADDR_FREEZE, 8'h00, "freeze");
		rd(refmon_pkg::ADDR_RAW, 8'h00, "raw");
		rd(8'h0E, 8'h00, "unmapped");
	endtask : t_reset
	// one indicator kind per entry: {enable, levels, expected flags}
	task automatic t_mask();
		logic [23:0] tb [4] = '{24'h661100, 24'h111103, 24'h112200, 24'h662203};
		foreach (tb[i]) begin
			wr(refmon_pkg::ADDR_ENABLE, tb[i][23:16]);
			pulse(tb[i][15:8]);
			rd(refmon_pkg::ADDR_RAW, tb[i][15:8], "raw");
			rd(refmon_pkg::ADDR_ISR, tb[i][7:0], "isr");
			`CHK("flags", tb[i][1:0], ref_fail_flags)
			clr();
		end
	endtask : t_mask
	task automatic t_freeze();
		wr(refmon_pkg::ADDR_FREEZE, refmon_pkg::FREEZE_ON);
		pulse(8'h02);
		rd(refmon_pkg::ADDR_ISR, 8'h00, "isr frozen");
		wr(refmon_pkg::ADDR_FREEZE, 8'h00);
		repeat (2) @(negedge ref_clk);
		rd(refmon_pkg::ADDR_ISR, 8'h01, "isr resumed");
		rd(refmon_pkg::ADDR_RAW, 8'h02, "raw resumed");
		clr();
	endtask : t_freeze
	// every drop and accept code, timed from the verdict output
	task automatic t_guard();
		int n;
		int lim;
		for (int c = 0; c < 4; c++) begin
			lim = c == 0 ? 1 : c == 1 ? 4 : c == 2 ? 8 : 16;
			wr(refmon_pkg::ADDR_DROP, 8'hA8 | 8'(c));
			wr(refmon_pkg::ADDR_ACCEPT, 8'h50 | 8'(c));
			@(negedge ref_clk);
			fail_level = 8'h04;
			n = 0;
			while (input_qualified[0] !== 1'b0 && n < 300) begin
				@(negedge ref_clk);
				n++;
			end
			`CHK("drop time", 1'b1, n >= lim + 1 && n <= lim + 3)
			`CHK("ref1 kept", 1'b1, input_qualified[1])
			rd(refmon_pkg::ADDR_RAW, 8'h0C, "raw gst");
			fail_level = 8'h00;
			n = 0;
			while (input_qualified[0] !== 1'b1 && n < 300) begin
				@(negedge ref_clk);
				n++;
			end
			lim = (2 * c + 2) * lim;
			`CHK("accept time", 1'b1, n >= lim + 1 && n <= lim + 4)
			clr();
		end
	endtask : t_guard
	// {setup, n wiring, edges ref0, edges ref1} over 400 cycles
	task automatic t_clock();
		logic [31:0] tb [4] = '{32'h10001414, 32'h13000A0A, 32'h10010014,
			32'h00011414};
		int c0;
		int c1;
		int e0;
		int e1;
		logic [1:0] pv;
		foreach (tb[i]) begin
			wr(refmon_pkg::ADDR_SETUP, tb[i][31:24]);
			m0 = tb[i][17:16];
			e0 = int'(tb[i][15:8]);
			e1 = int'(tb[i][7:0]);
			repeat (20) @(negedge ref_clk);
			c0 = 0;
			c1 = 0;
			pv = tracked_clk;
			repeat (400) begin
				@(negedge ref_clk);
				c0 += int'(tracked_clk[0] & ~pv[0]);
				c1 += int'(tracked_clk[1] & ~pv[1]);
				pv = tracked_clk;
			end
			`CHK("edges0", 1'b1, c0 + 1 >= e0 && c0 <= e0 + 1)
			`CHK("edges1", 1'b1, c1 + 1 >= e1 && c1 <= e1 + 1)
		end
	endtask : t_clock
	// hang guard: the whole run needs well under 20000 cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		repeat (4) @(negedge ref_clk);
		rstn = 1'b1;
		t_reset();
		t_mask();
		t_freeze();
		t_guard();
		t_clock();
		finish_test();
	end
endmodule : reference_monitor_config_tb
